// ### srdc_consts.svh
/*
 * constants of the switch reset domain control block: clock rate, release
 * delays, training deadline, strap width and status bit positions.
 * assumes inclusion by bare name from the block's files.
 */
`ifndef SRDC_CONSTS_SVH
`define SRDC_CONSTS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SRDC_CLK_PERIOD_NS 10
`define SRDC_POR_DELAY_NS 10000
`define SRDC_POR_DELAY_CYC ((`SRDC_POR_DELAY_NS + `SRDC_CLK_PERIOD_NS - 1) / `SRDC_CLK_PERIOD_NS)
`define SRDC_TRAIN_MAX_MS 80
`define SRDC_TRAIN_MAX_CYC ((`SRDC_TRAIN_MAX_MS * 1000000) / `SRDC_CLK_PERIOD_NS)
`define SRDC_CLK_DET_EDGES 16

// ----------------------------------------------------------------------
// widths, status layout and reset values
// ----------------------------------------------------------------------
`define SRDC_STRAP_W 8
`define SRDC_NUM_DS 3
`define SRDC_STAT_BUSY_BIT 4
`define SRDC_STAT_ERR_BIT 0
`define SRDC_STRAP_RST 8'h00

`endif

// ### srdc_pkg.sv
/*
 * types of the switch reset domain control block: state encodings and the
 * bundle of reset domains handed to the rest of the switch.
 * assumes nothing of its surroundings.
 */
package srdc_pkg;

   // ----------------------------------------------------------------------
   // state machines
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      SRDC_POR_PWR = 4'h1,
      SRDC_POR_CLK = 4'h2,
      SRDC_POR_DLY = 4'h4,
      SRDC_POR_DONE = 4'h8
   } srdc_por_state_type;

   typedef enum logic [3:0] {
      SRDC_LK_RESET = 4'h1,
      SRDC_LK_LOAD = 4'h2,
      SRDC_LK_TRAIN = 4'h4,
      SRDC_LK_DLDOWN = 4'h8
   } srdc_link_state_type;

   // ----------------------------------------------------------------------
   // reset domains, all active low
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic sticky_rst_n;
      logic aux_pm_rst_n;
      logic loadable_rst_n;
      logic eeprom_sm_rst_n;
      logic nonsticky_rst_n;
      logic port_rst_n;
   } srdc_domains_type;

endpackage

// ### srdc_rst_sync.sv
/*
 * two-flop synchroniser with asynchronous clear: the output falls at once
 * when arst_n falls and follows d two clock edges later otherwise.
 * assumes arst_n is glitch free.
 */
`timescale 1ns/100ps
`default_nettype none

module srdc_rst_sync (
   // clock and clear
   input wire logic clk,
   input wire logic arst_n,
   // data
   input wire logic d,
   output logic q
);

   logic meta_ff;
   logic q_ff;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= 1'b0;
         q_ff <= 1'b0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule

`default_nettype wire

// ### srdc_clk_detect.sv
/*
 * reference clock activity detector: synchronises the clock pin and counts
 * its edges once enabled; reports active after a fixed number of edges.
 * assumes the pin toggles slower than half the core clock rate.
 */
`timescale 1ns/100ps
`default_nettype none
`include "srdc_consts.svh"

module srdc_clk_detect #(
   parameter int EDGES = `SRDC_CLK_DET_EDGES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic en,
   input wire logic ref_clock_in,
   // status
   output logic active
);

   localparam int CW = $clog2(EDGES + 1);

   logic meta_ff;
   logic ref_ff;
   logic ref_q_ff;
   logic [CW-1:0] cnt_ff;

   // ----------------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b0;
         ref_ff <= 1'b0;
         ref_q_ff <= 1'b0;
      end else begin
         meta_ff <= ref_clock_in;
         ref_ff <= meta_ff;
         ref_q_ff <= ref_ff;
      end
   end

   // ----------------------------------------------------------------------
   // edge counter
   // ----------------------------------------------------------------------
   // restarts whenever power drops, so a stale count never releases reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= '0;
      end else if (!en) begin
         cnt_ff <= '0;
      end else if ((ref_ff != ref_q_ff) && (cnt_ff != CW'(EDGES))) begin
         cnt_ff <= cnt_ff + CW'(1);
      end
   end

   assign active = (cnt_ff == CW'(EDGES));

endmodule

`default_nettype wire

// ### srdc_reset_ctrl.sv
/*
 * switch reset domain control: builds power-on reset, synchronises global
 * and fundamental reset, derives the reset domains, latches straps, starts
 * the eeprom preload and steers link training and hot reset.
 * assumes eeprom done/fail and hot reset come from logic on clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "srdc_consts.svh"

module srdc_reset_ctrl #(
   parameter int TRAIN_MAX_CYC = `SRDC_TRAIN_MAX_CYC,
   parameter int NUM_DS = `SRDC_NUM_DS,
   parameter int STRAP_W = `SRDC_STRAP_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins
   input wire logic core_supply_sense,
   input wire logic ref_clock_in,
   input wire logic chip_global_reset_in,
   input wire logic fundamental_reset_in,
   input wire logic aux_power_state,
   input wire logic eeprom_present,
   input wire logic [STRAP_W-1:0] strap_in,
   // link and eeprom engine
   input wire logic hot_reset_rx,
   input wire logic eeprom_load_done,
   input wire logic eeprom_load_fail,
   // reset domains
   output srdc_pkg::srdc_domains_type domains,
   output logic combined_port_reset,
   output logic chip_ctrl_rst_n,
   output logic [NUM_DS-1:0] ds_port_rst_n,
   // status and control
   output logic [STRAP_W-1:0] strap_latched,
   output logic eeprom_load_start,
   output logic eeprom_load_busy,
   output logic [7:0] sb_status,
   output logic link_train_en,
   output logic dl_down
);

   localparam int TW = $clog2(TRAIN_MAX_CYC + 1);
   localparam int PW = $clog2(`SRDC_POR_DELAY_CYC + 1);

   srdc_pkg::srdc_por_state_type por_state_ff;
   srdc_pkg::srdc_link_state_type link_state_ff;
   logic pwr_ok, clk_active, chip_global_reset_in_n, fundamental_reset_in_n, aux_on;
   logic [STRAP_W-1:0] strap_meta_ff, strap_sync_ff, strap_ff;
   logic [PW-1:0] por_cnt_ff;
   logic [TW-1:0] train_cnt_ff;
   logic por_done_ff, fund_q_ff, busy_ff, err_ff;
   logic gl_rst_n, fund_rst_n, fund_rise, deadline;

   // ----------------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------------
   srdc_rst_sync u_pwr_sync (
      .clk(clk),
      .arst_n(reset_n),
      .d(core_supply_sense),
      .q(pwr_ok)
   );
   srdc_rst_sync u_aux_sync (
      .clk(clk),
      .arst_n(reset_n),
      .d(aux_power_state),
      .q(aux_on)
   );
   // the pin clears both flops at once; release waits two clean edges
   srdc_rst_sync u_chip_global_reset_in_sync (
      .clk(clk),
      .arst_n(reset_n & chip_global_reset_in),
      .d(1'b1),
      .q(chip_global_reset_in_n)
   );
   srdc_rst_sync u_fundamental_reset_in_sync (
      .clk(clk),
      .arst_n(reset_n & fundamental_reset_in),
      .d(1'b1),
      .q(fundamental_reset_in_n)
   );
   srdc_clk_detect u_clk_det (
      .clk(clk),
      .reset_n(reset_n),
      .en(pwr_ok),
      .ref_clock_in(ref_clock_in),
      .active(clk_active)
   );

   // ----------------------------------------------------------------------
   // power-on reset
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         por_state_ff <= srdc_pkg::SRDC_POR_PWR;
      end else if (!pwr_ok) begin
         por_state_ff <= srdc_pkg::SRDC_POR_PWR;
      end else begin
         unique case (por_state_ff)
            srdc_pkg::SRDC_POR_PWR: por_state_ff <= srdc_pkg::SRDC_POR_CLK;
            srdc_pkg::SRDC_POR_CLK: if (clk_active) por_state_ff <= srdc_pkg::SRDC_POR_DLY;
            srdc_pkg::SRDC_POR_DLY: begin
               if (por_cnt_ff == PW'(`SRDC_POR_DELAY_CYC - 1)) por_state_ff <= srdc_pkg::SRDC_POR_DONE;
            end
            srdc_pkg::SRDC_POR_DONE: por_state_ff <= srdc_pkg::SRDC_POR_DONE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         por_cnt_ff <= '0;
      end else if (por_state_ff == srdc_pkg::SRDC_POR_DLY) begin
         por_cnt_ff <= por_cnt_ff + PW'(1);
      end else begin
         por_cnt_ff <= '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         por_done_ff <= 1'b0;
      end else begin
         por_done_ff <= pwr_ok && (por_state_ff == srdc_pkg::SRDC_POR_DONE);
      end
   end

   // ----------------------------------------------------------------------
   // reset domains
   // ----------------------------------------------------------------------
   // sticky and aux machines ride out fundamental reset but not main power loss, so aux only hits fund
   assign gl_rst_n = por_done_ff & chip_global_reset_in_n;
   assign fund_rst_n = gl_rst_n & fundamental_reset_in_n & ~aux_on;
   assign domains.sticky_rst_n = gl_rst_n;
   assign domains.aux_pm_rst_n = gl_rst_n;
   assign domains.loadable_rst_n = fund_rst_n;
   assign domains.eeprom_sm_rst_n = fund_rst_n;
   assign domains.nonsticky_rst_n = fund_rst_n & ~dl_down;
   assign domains.port_rst_n = fund_rst_n & ~dl_down;
   assign combined_port_reset = ~domains.port_rst_n;
   assign chip_ctrl_rst_n = domains.port_rst_n;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DS; gi++) begin : g_ds
         assign ds_port_rst_n[gi] = domains.port_rst_n;
      end
   endgenerate

   // ----------------------------------------------------------------------
   // strap latch
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_meta_ff <= `SRDC_STRAP_RST;
         strap_sync_ff <= `SRDC_STRAP_RST;
         fund_q_ff <= 1'b0;
      end else begin
         strap_meta_ff <= strap_in;
         strap_sync_ff <= strap_meta_ff;
         fund_q_ff <= fund_rst_n;
      end
   end

   assign fund_rise = fund_rst_n & ~fund_q_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_ff <= `SRDC_STRAP_RST;
      end else if (fund_rise) begin
         strap_ff <= strap_sync_ff;
      end
   end

   assign strap_latched = strap_ff;

   // ----------------------------------------------------------------------
   // preload and link training
   // ----------------------------------------------------------------------
   // the host keeps fundamental reset low across power or clock loss,
   // so nothing here guards against a dying reference clock
   assign deadline = (train_cnt_ff == TW'(TRAIN_MAX_CYC - 1));
   assign eeprom_load_start = fund_rise && (link_state_ff == srdc_pkg::SRDC_LK_RESET) && eeprom_present;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         link_state_ff <= srdc_pkg::SRDC_LK_RESET;
      end else if (!fund_rst_n) begin
         link_state_ff <= srdc_pkg::SRDC_LK_RESET;
      end else begin
         unique case (link_state_ff)
            srdc_pkg::SRDC_LK_RESET: begin
               link_state_ff <= eeprom_present ? srdc_pkg::SRDC_LK_LOAD : srdc_pkg::SRDC_LK_TRAIN;
            end
            srdc_pkg::SRDC_LK_LOAD: begin
               if (eeprom_load_done || deadline) link_state_ff <= srdc_pkg::SRDC_LK_TRAIN;
            end
            srdc_pkg::SRDC_LK_TRAIN: if (hot_reset_rx) link_state_ff <= srdc_pkg::SRDC_LK_DLDOWN;
            srdc_pkg::SRDC_LK_DLDOWN: if (!hot_reset_rx) link_state_ff <= srdc_pkg::SRDC_LK_TRAIN;
         endcase
      end
   end

   // a slow eeprom is cut short so the training deadline always holds
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         train_cnt_ff <= '0;
      end else if (!fund_rst_n || (link_state_ff == srdc_pkg::SRDC_LK_TRAIN)) begin
         train_cnt_ff <= '0;
      end else if (!deadline) begin
         train_cnt_ff <= train_cnt_ff + TW'(1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_ff <= 1'b0;
      end else if (!fund_rst_n) begin
         busy_ff <= 1'b0;
      end else if (eeprom_load_start) begin
         busy_ff <= 1'b1;
      end else if ((link_state_ff == srdc_pkg::SRDC_LK_LOAD) && (eeprom_load_done || deadline)) begin
         busy_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         err_ff <= 1'b0;
      end else if (!fund_rst_n || eeprom_load_start) begin
         err_ff <= 1'b0;
      end else if ((link_state_ff == srdc_pkg::SRDC_LK_LOAD) && (eeprom_load_done || deadline)) begin
         err_ff <= eeprom_load_done ? eeprom_load_fail : 1'b1;
      end
   end

   assign eeprom_load_busy = busy_ff;
   assign link_train_en = (link_state_ff == srdc_pkg::SRDC_LK_TRAIN);
   assign dl_down = (link_state_ff == srdc_pkg::SRDC_LK_DLDOWN);

   always_comb begin
      sb_status = 8'h00;
      sb_status[`SRDC_STAT_BUSY_BIT] = busy_ff;
      sb_status[`SRDC_STAT_ERR_BIT] = err_ff;
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_por_delay;
      @(posedge clk) disable iff (!reset_n)
      $rose(por_state_ff == srdc_pkg::SRDC_POR_DLY) && pwr_ok |-> !por_done_ff [*8];
   endproperty
   a_por_delay: assert property (p_por_delay) else $error("por released before delay");
   property p_por_clears;
      @(posedge clk) disable iff (!reset_n)
      !por_done_ff |-> !domains.sticky_rst_n && !domains.aux_pm_rst_n && combined_port_reset;
   endproperty
   a_por_clears: assert property (p_por_clears) else $error("domain left free during por");
   // the link state register follows an async pin drop one edge later
   property p_chip_global_reset_in_full;
      @(posedge clk) disable iff (!reset_n)
      !chip_global_reset_in_n |-> (!domains.sticky_rst_n && !domains.loadable_rst_n) ##1 !link_train_en;
   endproperty
   a_chip_global_reset_in_full: assert property (p_chip_global_reset_in_full) else $error("global reset not full");
   property p_strap;
      @(posedge clk) disable iff (!reset_n)
      fund_rise |=> strap_latched == $past(strap_sync_ff);
   endproperty
   a_strap: assert property (p_strap) else $error("straps not latched on release");
   property p_preload;
      @(posedge clk) disable iff (!reset_n)
      fund_rise && eeprom_present |=> eeprom_load_busy && (link_state_ff == srdc_pkg::SRDC_LK_LOAD);
   endproperty
   a_preload: assert property (p_preload) else $error("preload not started");
   property p_train_deadline;
      @(posedge clk) disable iff (!reset_n)
      (link_state_ff == srdc_pkg::SRDC_LK_LOAD) && deadline |=> link_train_en || !fund_rst_n;
   endproperty
   a_train_deadline: assert property (p_train_deadline) else $error("training deadline missed");
   property p_fund_sticky;
      @(posedge clk) disable iff (!reset_n)
      gl_rst_n && !fundamental_reset_in_n |-> domains.sticky_rst_n && !domains.nonsticky_rst_n;
   endproperty
   a_fund_sticky: assert property (p_fund_sticky) else $error("fundamental reset hit sticky");
   property p_fund_aux;
      @(posedge clk) disable iff (!reset_n)
      !fundamental_reset_in_n && gl_rst_n |-> domains.aux_pm_rst_n && !domains.eeprom_sm_rst_n;
   endproperty
   a_fund_aux: assert property (p_fund_aux) else $error("fundamental reset hit aux machines");
   property p_hot;
      @(posedge clk) disable iff (!reset_n)
      link_train_en && hot_reset_rx && fund_rst_n |=> dl_down;
   endproperty
   a_hot: assert property (p_hot) else $error("hot reset ignored");
   property p_dldown;
      @(posedge clk) disable iff (!reset_n)
      dl_down && fund_rst_n |-> combined_port_reset && domains.loadable_rst_n && domains.sticky_rst_n;
   endproperty
   a_dldown: assert property (p_dldown) else $error("link-down domains wrong");
   property p_combined;
      @(posedge clk) disable iff (!reset_n)
      !combined_port_reset |-> por_done_ff && chip_global_reset_in_n && fundamental_reset_in_n && !dl_down;
   endproperty
   a_combined: assert property (p_combined) else $error("combined reset released early");
   property p_busy;
      @(posedge clk) disable iff (!reset_n)
      eeprom_load_busy == (link_state_ff == srdc_pkg::SRDC_LK_LOAD) && sb_status[`SRDC_STAT_BUSY_BIT] == busy_ff;
   endproperty
   a_busy: assert property (p_busy) else $error("busy bit out of step with preload");

endmodule

`default_nettype wire

// ### srdc_host_model.sv
/*
 * upstream link partner model: supplies power good, the reference clock,
 * the fundamental reset pin and the received hot reset level.
 * assumes the bench drives its request inputs on the rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none

module srdc_host_model (
   // clock
   input wire logic clk,
   // requests from the bench
   input wire logic pwr_on,
   input wire logic fundamental_reset_in_release,
   input wire logic hot_req,
   // pins toward the switch
   output logic core_supply_sense,
   output logic ref_clock_in,
   output logic fundamental_reset_in,
   output logic hot_reset_rx
);
   logic [1:0] div_ff;
   logic [2:0] down_ff;

   initial begin
      core_supply_sense = 1'b0;
      ref_clock_in = 1'b0;
      fundamental_reset_in = 1'b0;
      hot_reset_rx = 1'b0;
      div_ff = 2'h0;
      down_ff = 3'h7;
   end

   // hot reset is only sent on a link that is out of fundamental reset
   always @(posedge clk) begin
      hot_reset_rx <= hot_req && fundamental_reset_in;
   end

   // power down order: reset pin first, then clock, supply last
   always @(posedge clk) begin
      if (pwr_on) begin
         down_ff <= 3'h0;
         core_supply_sense <= 1'b1;
         fundamental_reset_in <= fundamental_reset_in_release && core_supply_sense;
      end else begin
         fundamental_reset_in <= 1'b0;
         if (down_ff != 3'h7) begin
            down_ff <= down_ff + 3'h1;
         end
         if (down_ff == 3'h6) begin
            core_supply_sense <= 1'b0;
         end
      end
   end

   // reference clock at a quarter of the core rate, stopped only after reset
   always @(posedge clk) begin
      div_ff <= div_ff + 2'h1;
      if (core_supply_sense && down_ff < 3'h3 && div_ff[0]) begin
         ref_clock_in <= ~ref_clock_in;
      end
   end

endmodule
`default_nettype wire

// ### tb_switch_reset_domain_control.sv
/*
 * self-checking bench of the reset domain control block with the host model.
 * assumes the design's preload timeout parameter is shortened to 200 cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_switch_reset_domain_control;
   logic clk, reset_n, pwr_on, fundamental_reset_in_release, hot_req;
   logic core_supply_sense, ref_clock_in, fundamental_reset_in, hot_reset_rx;
   logic chip_global_reset_in, aux_power_state, eeprom_present;
   logic eeprom_load_done, eeprom_load_fail, combined_port_reset, chip_ctrl_rst_n;
   logic eeprom_load_start, eeprom_load_busy, link_train_en, dl_down;
   logic [7:0] strap_in, strap_latched, sb_status, dom8;
   logic [2:0] ds_port_rst_n, flags;
   srdc_pkg::srdc_domains_type domains;
   int mismatches = 0;
   int n_tests = 0;

   assign dom8 = {2'h0, domains};
   assign flags = {link_train_en, eeprom_load_start, domains.sticky_rst_n};

   always #5 clk = ~clk;

   srdc_host_model host (.clk(clk), .pwr_on(pwr_on), .fundamental_reset_in_release(fundamental_reset_in_release), .hot_req(hot_req),
      .core_supply_sense(core_supply_sense), .ref_clock_in(ref_clock_in),
      .fundamental_reset_in(fundamental_reset_in), .hot_reset_rx(hot_reset_rx));

   srdc_reset_ctrl #(.TRAIN_MAX_CYC(200)) uut (.clk(clk), .reset_n(reset_n),
      .core_supply_sense(core_supply_sense), .ref_clock_in(ref_clock_in),
      .chip_global_reset_in(chip_global_reset_in), .fundamental_reset_in(fundamental_reset_in),
      .aux_power_state(aux_power_state), .eeprom_present(eeprom_present), .strap_in(strap_in),
      .hot_reset_rx(hot_reset_rx), .eeprom_load_done(eeprom_load_done),
      .eeprom_load_fail(eeprom_load_fail), .domains(domains), .combined_port_reset(combined_port_reset),
      .chip_ctrl_rst_n(chip_ctrl_rst_n), .ds_port_rst_n(ds_port_rst_n), .strap_latched(strap_latched),
      .eeprom_load_start(eeprom_load_start), .eeprom_load_busy(eeprom_load_busy),
      .sb_status(sb_status), .link_train_en(link_train_en), .dl_down(dl_down));

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task chk1(input string name, input logic exp, input logic got);
      chk(name, {7'h0, exp}, {7'h0, got});
   endtask

   // sample just after the edge so the edge's own updates have landed
   task tick;
      @(posedge clk);
      #1;
   endtask

   // bounded wait on a flag; running out ends the run
   task wait_flag(input int sel, input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         tick;
         if (flags[sel] === 1'b1) begin
            return;
         end
      end
      mismatches++;
      $display("wrong value wait %0d expected 1 seen 0", sel);
      report_and_stop;
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task t_power_on;
      int n;
      chk("reset domains", 8'h00, dom8);
      chk1("reset combined", 1'b1, combined_port_reset);
      chk("reset status", 8'h00, sb_status);
      @(posedge clk);
      reset_n <= 1'b1;
      pwr_on <= 1'b1;
      wait_flag(0, 1300, n);
      chk1("por delay", 1'b1, n >= 1030 && n < 1100);
      chk("por domains", 8'h30, dom8);
      chk1("por combined", 1'b1, combined_port_reset);
      $display("power_on done");
   endtask

   task t_fund_release;
      int n;
      @(posedge clk);
      strap_in <= 8'hA5;
      fundamental_reset_in_release <= 1'b1;
      wait_flag(1, 20, n);
      tick;
      chk1("busy", 1'b1, eeprom_load_busy);
      chk("load status", 8'h10, sb_status);
      chk("straps", 8'hA5, strap_latched);
      chk1("early training", 1'b0, link_train_en);
      chk("up domains", 8'h3F, dom8);
      chk1("up combined", 1'b0, combined_port_reset);
      @(posedge clk);
      strap_in <= 8'h3C;
      eeprom_load_done <= 1'b1;
      @(posedge clk);
      eeprom_load_done <= 1'b0;
      #1;
      chk1("busy end", 1'b0, eeprom_load_busy);
      chk("ok status", 8'h00, sb_status);
      chk1("training", 1'b1, link_train_en);
      chk("straps static", 8'hA5, strap_latched);
      $display("fund_release done");
   endtask

   task t_hot_reset;
      @(posedge clk);
      hot_req <= 1'b1;
      repeat (3) tick;
      chk1("dl down", 1'b1, dl_down);
      chk1("hot training", 1'b0, link_train_en);
      chk("hot domains", 8'h3C, dom8);
      chk1("hot combined", 1'b1, combined_port_reset);
      chk("hot ports", 8'h00, {4'h0, chip_ctrl_rst_n, ds_port_rst_n});
      @(posedge clk);
      hot_req <= 1'b0;
      repeat (3) tick;
      chk1("dl up", 1'b0, dl_down);
      chk1("retrain", 1'b1, link_train_en);
      chk("up ports", 8'h0F, {4'h0, chip_ctrl_rst_n, ds_port_rst_n});
      chk("no relatch", 8'hA5, strap_latched);
      chk1("no reload", 1'b0, eeprom_load_busy);
      $display("hot_reset done");
   endtask

   task t_fund_deadline;
      int n;
      @(posedge clk);
      fundamental_reset_in_release <= 1'b0;
      repeat (2) tick;
      chk("fund domains", 8'h30, dom8);
      chk1("fund training", 1'b0, link_train_en);
      @(posedge clk);
      fundamental_reset_in_release <= 1'b1;
      wait_flag(2, 260, n);
      chk1("deadline", 1'b1, n < 210);
      chk("late status", 8'h01, sb_status);
      chk("new straps", 8'h3C, strap_latched);
      $display("fund_deadline done");
   endtask

   task t_global_aux;
      int n;
      @(posedge clk);
      aux_power_state <= 1'b1;
      repeat (4) tick;
      chk("aux domains", 8'h30, dom8);
      @(posedge clk);
      chip_global_reset_in <= 1'b0;
      #1;
      chk("global async", 8'h00, dom8);
      tick;
      chk("global status", 8'h00, sb_status);
      @(posedge clk);
      chip_global_reset_in <= 1'b1;
      aux_power_state <= 1'b0;
      tick;
      chk1("sync release", 1'b0, domains.sticky_rst_n);
      wait_flag(1, 1300, n);
      chk("global up", 8'h3F, dom8);
      @(posedge clk);
      eeprom_load_done <= 1'b1;
      eeprom_load_fail <= 1'b1;
      @(posedge clk);
      eeprom_load_done <= 1'b0;
      eeprom_load_fail <= 1'b0;
      #1;
      chk("fail status", 8'h01, sb_status);
      $display("global_aux done");
   endtask

   // without an eeprom the link goes straight to training, no busy phase
   task t_no_eeprom;
      int n;
      @(posedge clk);
      fundamental_reset_in_release <= 1'b0;
      eeprom_present <= 1'b0;
      repeat (3) tick;
      chk1("noee held", 1'b0, link_train_en);
      @(posedge clk);
      fundamental_reset_in_release <= 1'b1;
      wait_flag(2, 20, n);
      chk1("noee delay", 1'b1, n == 4);
      chk("noee status", 8'h00, sb_status);
      chk1("noee busy", 1'b0, eeprom_load_busy);
      chk("noee domains", 8'h3F, dom8);
      $display("no_eeprom done");
   endtask

   task t_power_down;
      @(posedge clk);
      pwr_on <= 1'b0;
      repeat (3) tick;
      chk("down domains", 8'h30, dom8);
      chk1("supply held", 1'b1, core_supply_sense);
      $display("power_down done");
   endtask

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      pwr_on = 1'b0;
      fundamental_reset_in_release = 1'b0;
      hot_req = 1'b0;
      chip_global_reset_in = 1'b1;
      aux_power_state = 1'b0;
      eeprom_present = 1'b1;
      strap_in = 8'h00;
      eeprom_load_done = 1'b0;
      eeprom_load_fail = 1'b0;
      repeat (2) @(posedge clk);
      t_power_on;
      t_fund_release;
      t_hot_reset;
      t_fund_deadline;
      t_global_aux;
      t_no_eeprom;
      t_power_down;
      report_and_stop;
   end

endmodule
`default_nettype wire
